/* File: design/output_stage_regs.vh */
// Register offsets, field positions, reset values and timing counts
// for the output stage control register group.
// Assumes a 100 MHz system clock.
`ifndef OUTPUT_STAGE_REGS_VH
`define OUTPUT_STAGE_REGS_VH

`define REG_RESERVED_SLOT        8'h27
`define REG_OUTPUT_STAGE_CONTROL 8'h28
`define REG_DAC_OUTPUT_SWITCHING 8'h29
`define REG_POP_REDUCTION_TIMING 8'h2A
`define REG_LEFT_DAC_VOLUME      8'h2B
`define REG_RIGHT_DAC_VOLUME     8'h2C

`define RST_OUTPUT_STAGE_CONTROL 8'h00
`define RST_DAC_OUTPUT_SWITCHING 8'h00
`define RST_POP_REDUCTION_TIMING 8'h00
`define RST_DAC_VOLUME           8'h80

// Writable bits; bits clear in these masks always read back as zero
`define MASK_DAC_OUTPUT_SWITCHING 8'hF3
`define MASK_POP_REDUCTION_TIMING 8'hFE

`define MUTE_BIT   7
`define STEP_ONE   2'h0
`define STEP_TWO   2'h1
`define STEP_NONE  2'h2
`define LINK_L_FOLLOWS_R 2'h1
`define LINK_R_FOLLOWS_L 2'h2

// Timing in microseconds; cycles per microsecond at 100 MHz
`define CLOCK_MHZ          100
`define CYCLES_PER_US      (`CLOCK_MHZ)
`define DELAY_US_10        10
`define DELAY_US_100       100
`define DELAY_US_1000      1000
`define DELAY_US_10000     10000
`define DELAY_US_50000     50000
`define DELAY_US_100000    100000
`define DELAY_US_200000    200000
`define DELAY_US_400000    400000
`define DELAY_US_800000    800000
`define DELAY_US_2000000   2000000
`define DELAY_US_4000000   4000000
`define RAMP_US_1          1000
`define RAMP_US_2          2000
`define RAMP_US_4          4000

`endif

/* File: design/output_stage_control_regs.v */
// Output stage control registers with left/right DAC volume stepping.
// Assumes a byte-wide register port from the control bus decoder and a
// one-cycle sample-rate strobe synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
`include "output_stage_regs.vh"

// How it works
// - Bits 7:6 of 0x28 choose common-mode level, reset 00.
// - Bits 5:4 of 0x28 choose left second-line bypass mode.
// - Bits 3:2 of 0x28 choose right second-line bypass mode.
// - Bits 1:0 of 0x28 set soft-step rate; 10 immediate.
// - Bits 7:6 of 0x29 route left DAC to one of three paths.
// - Bits 5:4 of 0x29 route right DAC to one of three paths.
// - Bits 1:0 of 0x29 link left and right volumes.
// - Bits 7:4 of 0x2A set driver power-on delay, zero to four seconds.
// - Bits 3:2 of 0x2A set driver ramp-up step time.
// - Bit 1 of 0x2A picks weak common-mode source.
// - Bit 7 of 0x2B mutes left DAC, resets to one.
// - Bits 6:0 of 0x2B attenuate left DAC, 0.5 dB per code.
// - Right DAC register has same mute and volume layout.
module output_stage_control_regs (
   input  wire       clock,
   input  wire       sys_rst,
   input  wire [7:0] reg_addr,
   input  wire       reg_wr,
   input  wire [7:0] reg_wdata,
   output reg  [7:0] reg_rdata,
   input  wire       sample_strobe,
   input  wire       driver_power_request,
   output reg  [1:0] common_mode_select,
   output reg  [1:0] left_bypass_select,
   output reg  [1:0] right_bypass_select,
   output reg  [1:0] left_dac_path_select,
   output reg  [1:0] right_dac_path_select,
   output reg        weak_cm_bandgap,
   output reg        left_dac_mute,
   output reg  [6:0] left_dac_atten,
   output reg        right_dac_mute,
   output reg  [6:0] right_dac_atten,
   output reg        driver_power_ready,
   output reg        ramp_step
);

   // ---------------------------------------------------------------
   // Register storage
   // ---------------------------------------------------------------
   reg [7:0] output_stage_control_ff;
   reg [7:0] dac_output_switching_ff;
   reg [7:0] pop_reduction_timing_ff;
   reg [7:0] left_dac_volume_ff;
   reg [7:0] right_dac_volume_ff;

   wire wr_stage = reg_wr && (reg_addr == `REG_OUTPUT_STAGE_CONTROL);
   wire wr_switch = reg_wr && (reg_addr == `REG_DAC_OUTPUT_SWITCHING);
   wire wr_pop = reg_wr && (reg_addr == `REG_POP_REDUCTION_TIMING);
   wire wr_left = reg_wr && (reg_addr == `REG_LEFT_DAC_VOLUME);
   wire wr_right = reg_wr && (reg_addr == `REG_RIGHT_DAC_VOLUME);

   always @(posedge clock) begin
      if (sys_rst) begin
         output_stage_control_ff <= `RST_OUTPUT_STAGE_CONTROL;
         dac_output_switching_ff <= `RST_DAC_OUTPUT_SWITCHING;
         pop_reduction_timing_ff <= `RST_POP_REDUCTION_TIMING;
         left_dac_volume_ff      <= `RST_DAC_VOLUME;
         right_dac_volume_ff     <= `RST_DAC_VOLUME;
      end else begin
         if (wr_stage && reg_wdata[1:0] != 2'h3) begin
            output_stage_control_ff <= reg_wdata;
         end
         if (wr_switch) begin
            dac_output_switching_ff <= reg_wdata & `MASK_DAC_OUTPUT_SWITCHING;
         end
         if (wr_pop) begin
            pop_reduction_timing_ff <= reg_wdata & `MASK_POP_REDUCTION_TIMING;
         end
         if (wr_left) begin
            left_dac_volume_ff <= reg_wdata;
         end
         if (wr_right) begin
            right_dac_volume_ff <= reg_wdata;
         end
      end
   end

   // ---------------------------------------------------------------
   // Read-back
   // ---------------------------------------------------------------
   always @* begin
      case (reg_addr)
         `REG_OUTPUT_STAGE_CONTROL: reg_rdata = output_stage_control_ff;
         `REG_DAC_OUTPUT_SWITCHING: reg_rdata = dac_output_switching_ff;
         `REG_POP_REDUCTION_TIMING: reg_rdata = pop_reduction_timing_ff;
         `REG_LEFT_DAC_VOLUME:      reg_rdata = left_dac_volume_ff;
         `REG_RIGHT_DAC_VOLUME:     reg_rdata = right_dac_volume_ff;
         default:                   reg_rdata = 8'h00;
      endcase
   end

   // ---------------------------------------------------------------
   // Static field outputs
   // ---------------------------------------------------------------
   always @(posedge clock) begin
      if (sys_rst) begin
         common_mode_select    <= 2'h0;
         left_bypass_select    <= 2'h0;
         right_bypass_select   <= 2'h0;
         left_dac_path_select  <= 2'h0;
         right_dac_path_select <= 2'h0;
         weak_cm_bandgap       <= 1'b0;
      end else begin
         common_mode_select    <= output_stage_control_ff[7:6];
         left_bypass_select    <= output_stage_control_ff[5:4];
         right_bypass_select   <= output_stage_control_ff[3:2];
         left_dac_path_select  <= dac_output_switching_ff[7:6];
         right_dac_path_select <= dac_output_switching_ff[5:4];
         weak_cm_bandgap       <= pop_reduction_timing_ff[1];
      end
   end

   // ---------------------------------------------------------------
   // Volume linking and soft stepping
   // ---------------------------------------------------------------
   wire [1:0] link_mode = dac_output_switching_ff[1:0];
   wire [1:0] step_mode = output_stage_control_ff[1:0];
   reg  [7:0] left_target;
   reg  [7:0] right_target;
   reg        half_ff;

   always @* begin
      left_target  = left_dac_volume_ff;
      right_target = right_dac_volume_ff;
      if (link_mode == `LINK_L_FOLLOWS_R) begin
         left_target = right_dac_volume_ff;
      end else if (link_mode == `LINK_R_FOLLOWS_L) begin
         right_target = left_dac_volume_ff;
      end
   end

   wire step_now = (step_mode == `STEP_ONE && sample_strobe) ||
                   (step_mode == `STEP_TWO && sample_strobe && half_ff);

   function [6:0] step_toward;
      input [6:0] cur;
      input [6:0] tgt;
      begin
         if (cur < tgt) step_toward = cur + 7'h01;
         else if (cur > tgt) step_toward = cur - 7'h01;
         else step_toward = cur;
      end
   endfunction

   always @(posedge clock) begin
      if (sys_rst) begin
         half_ff         <= 1'b0;
         left_dac_mute   <= 1'b1;
         right_dac_mute  <= 1'b1;
         left_dac_atten  <= 7'h00;
         right_dac_atten <= 7'h00;
      end else begin
         if (sample_strobe) begin
            half_ff <= ~half_ff;
         end
         left_dac_mute  <= left_target[`MUTE_BIT];
         right_dac_mute <= right_target[`MUTE_BIT];
         if (step_mode == `STEP_NONE) begin
            left_dac_atten  <= left_target[6:0];
            right_dac_atten <= right_target[6:0];
         end else if (step_now) begin
            left_dac_atten  <= step_toward(left_dac_atten, left_target[6:0]);
            right_dac_atten <= step_toward(right_dac_atten, right_target[6:0]);
         end
      end
   end

   // ---------------------------------------------------------------
   // Driver power-on delay and ramp step timer
   // ---------------------------------------------------------------
   function [31:0] delay_cycles;
      input [3:0] code;
      begin
         case (code)
            4'h0: delay_cycles = 32'h0;
            4'h1: delay_cycles = `DELAY_US_10 * `CYCLES_PER_US;
            4'h2: delay_cycles = `DELAY_US_100 * `CYCLES_PER_US;
            4'h3: delay_cycles = `DELAY_US_1000 * `CYCLES_PER_US;
            4'h4: delay_cycles = `DELAY_US_10000 * `CYCLES_PER_US;
            4'h5: delay_cycles = `DELAY_US_50000 * `CYCLES_PER_US;
            4'h6: delay_cycles = `DELAY_US_100000 * `CYCLES_PER_US;
            4'h7: delay_cycles = `DELAY_US_200000 * `CYCLES_PER_US;
            4'h8: delay_cycles = `DELAY_US_400000 * `CYCLES_PER_US;
            4'h9: delay_cycles = `DELAY_US_800000 * `CYCLES_PER_US;
            4'hA: delay_cycles = `DELAY_US_2000000 * `CYCLES_PER_US;
            4'hB: delay_cycles = `DELAY_US_4000000 * `CYCLES_PER_US;
            default: delay_cycles = 32'h0;
         endcase
      end
   endfunction

   function [31:0] ramp_cycles;
      input [1:0] code;
      begin
         case (code)
            2'h1: ramp_cycles = `RAMP_US_1 * `CYCLES_PER_US;
            2'h2: ramp_cycles = `RAMP_US_2 * `CYCLES_PER_US;
            2'h3: ramp_cycles = `RAMP_US_4 * `CYCLES_PER_US;
            default: ramp_cycles = 32'h0;
         endcase
      end
   endfunction

   reg [31:0] delay_count_ff;
   reg [31:0] ramp_count_ff;
   wire [31:0] delay_target = delay_cycles(pop_reduction_timing_ff[7:4]);
   wire [31:0] ramp_target = ramp_cycles(pop_reduction_timing_ff[3:2]);

   always @(posedge clock) begin
      if (sys_rst) begin
         delay_count_ff     <= 32'h0;
         ramp_count_ff      <= 32'h0;
         driver_power_ready <= 1'b0;
         ramp_step          <= 1'b0;
      end else begin
         ramp_step <= 1'b0;
         if (!driver_power_request) begin
            delay_count_ff     <= 32'h0;
            ramp_count_ff      <= 32'h0;
            driver_power_ready <= 1'b0;
         end else if (!driver_power_ready) begin
            if (delay_count_ff >= delay_target) begin
               driver_power_ready <= 1'b1;
            end else begin
               delay_count_ff <= delay_count_ff + 32'h1;
            end
         end else if (ramp_count_ff + 32'h1 >= ramp_target) begin
            ramp_count_ff <= 32'h0;
            ramp_step     <= 1'b1;
         end else begin
            ramp_count_ff <= ramp_count_ff + 32'h1;
         end
      end
   end

endmodule // output_stage_control_regs
`default_nettype wire

/* File: verification/output_stage_control_regs_assertions.sv */
// Concurrent checks on the output stage control register ports.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module output_stage_control_regs_assertions (
   input wire logic       clock,
   input wire logic       sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic       driver_power_request,
   input wire logic [1:0] common_mode_select,
   input wire logic [1:0] left_bypass_select,
   input wire logic [1:0] right_bypass_select,
   input wire logic [1:0] left_dac_path_select,
   input wire logic [1:0] right_dac_path_select,
   input wire logic       weak_cm_bandgap,
   input wire logic       left_dac_mute,
   input wire logic [6:0] left_dac_atten,
   input wire logic       driver_power_ready,
   input wire logic       ramp_step
);
   // ----------------------------------------
   // Shadow of link and step mode
   // ----------------------------------------
   logic [1:0] link_ff;
   logic [1:0] step_ff;
   wire  logic w28 = reg_wr && (reg_addr == 8'h28);
   wire  logic w29 = reg_wr && (reg_addr == 8'h29);
   always @(posedge clock) begin
      if (sys_rst) begin
         link_ff <= 2'h0;
         step_ff <= 2'h0;
      end else begin
         if (w29)
            link_ff <= reg_wdata[1:0];
         if (w28 && reg_wdata[1:0] != 2'h3)
            step_ff <= reg_wdata[1:0];
      end
   end
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   a_reserved_zero: assert property (reg_addr == 8'h27 |-> reg_rdata == 8'h00)
      else $error("reserved offset read nonzero");
   a_stage_fields: assert property ((w28 && reg_wdata[1:0] != 2'h3) ##1 !reg_wr [*3] |->
      {common_mode_select, left_bypass_select, right_bypass_select} == $past(reg_wdata[7:2], 3))
      else $error("stage fields differ from write");
   a_step_refused: assert property ((w28 && reg_wdata[1:0] == 2'h3) ##1 !reg_wr [*3] |->
      $stable(common_mode_select) && $past(common_mode_select, 3) == common_mode_select)
      else $error("reserved step write took effect");
   a_path_fields: assert property (w29 ##1 !reg_wr [*3] |->
      {left_dac_path_select, right_dac_path_select} == $past(reg_wdata[7:4], 3))
      else $error("path fields differ from write");
   a_weak_source: assert property ((reg_wr && reg_addr == 8'h2A) ##1 !reg_wr [*3] |->
      weak_cm_bandgap == $past(reg_wdata[1], 3))
      else $error("weak source differs from write");
   a_reserved_bits: assert property (!((reg_addr == 8'h29 && reg_rdata[3:2] != 2'h0) ||
      (reg_addr == 8'h2A && reg_rdata[0])))
      else $error("reserved bits read nonzero");
   a_left_mute: assert property ((reg_wr && reg_addr == 8'h2B && link_ff != 2'h1)
      ##1 !reg_wr [*3] |-> left_dac_mute == $past(reg_wdata[7], 3))
      else $error("left mute differs from write");
   a_link_follow: assert property ((reg_wr && reg_addr == 8'h2C && link_ff == 2'h1)
      ##1 !reg_wr [*3] |-> left_dac_mute == $past(reg_wdata[7], 3))
      else $error("left mute not following right");
   a_step_size: assert property (step_ff != 2'h2 && $past(step_ff) != 2'h2 &&
      $past(step_ff, 2) != 2'h2 |-> 7'(7'(left_dac_atten - $past(left_dac_atten)) + 7'h1) <= 7'h2)
      else $error("attenuation moved more than one code");
   a_power_clear: assert property (!driver_power_request |=> !driver_power_ready && !ramp_step)
      else $error("driver ready without request");
endmodule // output_stage_control_regs_assertions
`default_nettype wire

/* File: verification/output_stage_control_regs_tb.sv */
// Self-checking bench for the output stage control registers.
// Assumes the design and its header are compiled first.
`timescale 1ns/1ps
`default_nettype none
module output_stage_control_regs_tb;
   logic        clock = 1'b0;
   logic        sys_rst = 1'b1;
   logic [7:0]  reg_addr = 8'h00;
   logic        reg_wr = 1'b0;
   logic [7:0]  reg_wdata = 8'h00;
   logic        sample_strobe = 1'b0;
   logic        driver_power_request = 1'b0;
   wire  [7:0]  reg_rdata;
   wire  [1:0]  common_mode_select, left_bypass_select, right_bypass_select;
   wire  [1:0]  left_dac_path_select, right_dac_path_select;
   wire         weak_cm_bandgap, left_dac_mute, right_dac_mute;
   wire  [6:0]  left_dac_atten, right_dac_atten;
   wire         driver_power_ready, ramp_step;
   int          bad_count = 0;
   int          checks_done = 0;
   int          cycles = 0;
   // Address, write data, expected read back
   // Reserved offset and reserved bits are never written; 0x27 is only read
   logic [23:0] rows [8] = '{24'h28E6E6, 24'h281BE6, 24'h299191, 24'h2AB6B6,
                             24'h2B7F7F, 24'h2C8585, 24'h2DFF00, 24'h40AA00};
   output_stage_control_regs u_output_stage_control_regs (.clock, .sys_rst, .reg_addr,
      .reg_wr, .reg_wdata, .reg_rdata, .sample_strobe, .driver_power_request,
      .common_mode_select, .left_bypass_select, .right_bypass_select, .left_dac_path_select,
      .right_dac_path_select, .weak_cm_bandgap, .left_dac_mute, .left_dac_atten,
      .right_dac_mute, .right_dac_atten, .driver_power_ready, .ramp_step);
   initial begin
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         wrap_up();
      end
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      reg_addr <= a;
      @(negedge clock);
      chk(reg_rdata, exp);
   endtask
   task automatic strobes(input int n);
      repeat (n) begin
         @(posedge clock);
         sample_strobe <= 1'b1;
         @(posedge clock);
         sample_strobe <= 1'b0;
         repeat (2) @(posedge clock);
      end
   endtask
   task automatic settle;
      repeat (4) @(posedge clock);
      @(negedge clock);
   endtask
   task automatic reset_dut;
      @(posedge clock);
      sys_rst <= 1'b1;
      repeat (20) @(posedge clock);
      sys_rst <= 1'b0;
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      reset_dut();
      for (int i = 0; i < 8; i++) begin
         wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16], rows[i][7:0]);
         repeat (4) @(posedge clock);
      end
      settle();
      chk(8'({common_mode_select, left_bypass_select, right_bypass_select}), 8'h39);
      chk(8'({left_dac_path_select, right_dac_path_select, weak_cm_bandgap}), 8'h13);
      chk({left_dac_mute, left_dac_atten}, 8'h85);
      chk({right_dac_mute, right_dac_atten}, 8'h85);
      $display("test register rows done");
      reset_dut();
      for (int a = 'h27; a <= 'h2C; a++) rd(8'(a), a > 'h2A ? 8'h80 : 8'h00);
      chk({left_dac_mute, left_dac_atten}, 8'h80);
      $display("test reset values done");
      wr(8'h28, 8'h02);
      wr(8'h29, 8'h02);
      wr(8'h2B, 8'h0A);
      settle();
      chk({right_dac_mute, right_dac_atten}, 8'h0A);
      chk({left_dac_mute, left_dac_atten}, 8'h0A);
      wr(8'h29, 8'h00);
      wr(8'h28, 8'h00);
      wr(8'h2B, 8'h03);
      strobes(3);
      chk(8'(left_dac_atten), 8'h07);
      strobes(5);
      chk(8'(left_dac_atten), 8'h03);
      wr(8'h28, 8'h01);
      wr(8'h2B, 8'h05);
      settle();
      chk(8'(left_dac_atten), 8'h03);
      strobes(4);
      chk(8'(left_dac_atten), 8'h05);
      $display("test volume stepping done");
      wr(8'h2A, 8'h00);
      driver_power_request <= 1'b1;
      settle();
      chk(8'({driver_power_ready, ramp_step}), 8'h03);
      @(posedge clock);
      driver_power_request <= 1'b0;
      settle();
      chk(8'(driver_power_ready), 8'h00);
      wr(8'h2A, 8'h10);
      driver_power_request <= 1'b1;
      repeat (1000) @(posedge clock);
      @(negedge clock);
      chk(8'(driver_power_ready), 8'h00);
      @(posedge clock);
      @(negedge clock);
      chk(8'(driver_power_ready), 8'h01);
      $display("test power timer done");
      wrap_up();
   end
endmodule // output_stage_control_regs_tb
bind output_stage_control_regs output_stage_control_regs_assertions
   u_output_stage_control_regs_assertions (.clock, .sys_rst, .reg_addr, .reg_wr,
   .reg_wdata, .reg_rdata, .driver_power_request, .common_mode_select,
   .left_bypass_select, .right_bypass_select, .left_dac_path_select,
   .right_dac_path_select, .weak_cm_bandgap, .left_dac_mute, .left_dac_atten,
   .driver_power_ready, .ramp_step);
`default_nettype wire
